// >>> hdl/tcdma_top.sv
`timescale 1ns/1ps
`include "tcdma_map.svh"

// How it works
// - simultaneous requests: high-priority channel goes first
// - fixed mode: high channel keeps bus while requesting
// - destination idle release lets low take one
// - high request pre-empts low at transfer boundary
// - equal priority rotates after every transfer
// - rotation resets to channel 1 on release
// - six registers configure each channel
// - pointers are 20 bits from low/high words
// - upper pointer bits drive address even for I/O
// - source address fetch, destination address deposit
// - space bit set memory, clear I/O
// - step up/down bits move pointer; equal holds
// - step is two for word, one byte
// - width bit set word, clear byte
// - terminal stop ends; irq needs stop too
// - two-bit sync kind selects synchronisation
// - rank bit set gives high priority
// - timer select uses timer two, ignores pin
// - software writes change arm flag only with guard set
// - inactive, terminated/suspended or released ends high run
// - unsynchronised starts when armed; code 11 reserved
// - terminal stop disarms at zero; unsync always
// - destination sync adds two released idle cycles
module tcdma_top
  import tcdma_pkg::*;
(
  input  wire logic        SYS_CLK,      // system clock
  input  wire logic        RSTN,         // async reset, active low
  input  wire logic        PSEL,         // apb select
  input  wire logic        PENABLE,      // apb enable
  input  wire logic        PWRITE,       // apb direction
  input  wire logic [11:0] PADDR,        // apb byte address
  input  wire logic [31:0] PWDATA,       // apb write data
  output logic      [31:0] PRDATA,       // apb read data
  output logic             PREADY,       // apb ready
  output logic             PSLVERR,      // apb error
  input  wire logic [1:0]  EXT_REQ_PIN,  // external request per channel
  input  wire logic        TIMER2_REQ,   // timer two request pulse
  input  wire logic        SUSPEND,      // halt transfers at boundary
  output logic             BUS_REQ,      // transfer pending to bus unit
  input  wire logic        BUS_DONE,     // bus unit finished a phase
  output logic      [19:0] BUS_ADDR,     // transfer address
  output logic             BUS_MEM,      // 1 memory, 0 I/O space
  output logic             BUS_WRITE,    // 1 in deposit phase
  output logic             BUS_WORD,     // 1 word, 0 byte
  output logic             BUS_CHAN,     // owning channel
  output logic      [1:0]  IRQ_REQ       // terminal-count interrupt per channel
);

  logic [15:0]  src_ptr_lo_reg [2];
  logic [15:0]  src_ptr_hi_reg [2];
  logic [15:0]  dst_ptr_lo_reg [2];
  logic [15:0]  dst_ptr_hi_reg [2];
  logic [15:0]  count_reg      [2];
  logic [15:0]  chan_ctrl_reg  [2];
  logic [1:0]   timer_pend_reg;
  logic [1:0]   irq_reg;
  tcdma_state_t state_reg;
  logic         chan_reg;
  logic         rot_top_reg;
  logic         last_dst_reg;
  logic [1:0]   idle_cnt_reg;
  logic         yield_reg;

  logic [1:0]   req;
  logic [1:0]   high;
  logic         grant;
  logic         grant_valid;
  logic         xfer_end;
  logic         wr_en;
  logic         rd_en;
  logic         sel_ch;
  logic [11:0]  sel_off;
  logic [19:0]  src_addr [2];
  logic [19:0]  dst_addr [2];
  logic [19:0]  src_adj;
  logic [19:0]  dst_adj;
  logic [19:0]  step;

  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && !PWRITE;
  assign sel_ch  = PADDR[5];
  assign sel_off = {7'h00, PADDR[4:0]};
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;

  // pointer assembly and request qualification
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      src_addr[i] = {src_ptr_hi_reg[i][3:0], src_ptr_lo_reg[i]};
      dst_addr[i] = {dst_ptr_hi_reg[i][3:0], dst_ptr_lo_reg[i]};
      high[i] = chan_ctrl_reg[i][`TCDMA_B_RANK_HIGH];
      if (!chan_ctrl_reg[i][`TCDMA_B_ARM] || SUSPEND) begin
        req[i] = 1'b0;
      end else if (chan_ctrl_reg[i][`TCDMA_B_SYNC_HI:`TCDMA_B_SYNC_LO] == SYNC_NONE) begin
        req[i] = 1'b1;
      end else if (chan_ctrl_reg[i][`TCDMA_B_TIMER_SEL]) begin
        req[i] = timer_pend_reg[i];
      end else begin
        req[i] = EXT_REQ_PIN[i];
      end
    end
  end

  // arbitration at each transfer boundary
  always_comb begin
    grant_valid = |req;
    if (req == 2'b11) begin
      if (high[0] != high[1]) begin
        // high channel that just released the bus lets low take one
        if (yield_reg && chan_reg == high[1]) begin
          grant = ~high[1];
        end else begin
          grant = high[1];
        end
      end else begin
        grant = rot_top_reg;
      end
    end else begin
      grant = req[1];
    end
  end

  // rotation pointer: channel 1 on top after release
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rot_top_reg <= 1'b1;
    end else if (state_reg == ST_RELEASE || (state_reg == ST_IDLE && !grant_valid)) begin
      rot_top_reg <= 1'b1;
    end else if (xfer_end) begin
      rot_top_reg <= ~chan_reg;
    end
  end

  // set by a destination-synchronised transfer, dropped by any other
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      yield_reg <= 1'b0;
    end else if (xfer_end) begin
      yield_reg <= (chan_ctrl_reg[chan_reg][`TCDMA_B_SYNC_HI:`TCDMA_B_SYNC_LO]
                    == SYNC_DST);
    end else if (state_reg == ST_IDLE && !grant_valid) begin
      yield_reg <= 1'b0;
    end
  end

  assign xfer_end = (state_reg == ST_DEPOSIT) && BUS_DONE;

  // transfer sequencer
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg    <= ST_IDLE;
      chan_reg     <= 1'b0;
      idle_cnt_reg <= 2'h0;
      last_dst_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (grant_valid) begin
            chan_reg  <= grant;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (BUS_DONE) begin
            state_reg <= ST_DEPOSIT;
          end
        end
        ST_DEPOSIT: begin
          if (BUS_DONE) begin
            last_dst_reg <= (chan_ctrl_reg[chan_reg][`TCDMA_B_SYNC_HI:`TCDMA_B_SYNC_LO]
                             == SYNC_DST);
            if (chan_ctrl_reg[chan_reg][`TCDMA_B_SYNC_HI:`TCDMA_B_SYNC_LO] == SYNC_DST) begin
              idle_cnt_reg <= `TCDMA_IDLE_CYCLES;
              state_reg    <= ST_RELEASE;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_RELEASE: begin
          idle_cnt_reg <= idle_cnt_reg - 2'h1;
          if (idle_cnt_reg == 2'h1) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // bus outputs: source on fetch, destination on deposit
  always_comb begin
    BUS_REQ   = (state_reg == ST_FETCH) || (state_reg == ST_DEPOSIT);
    BUS_WRITE = (state_reg == ST_DEPOSIT);
    BUS_CHAN  = chan_reg;
    BUS_WORD  = chan_ctrl_reg[chan_reg][`TCDMA_B_WORD];
    if (state_reg == ST_DEPOSIT) begin
      BUS_ADDR = dst_addr[chan_reg];
      BUS_MEM  = chan_ctrl_reg[chan_reg][`TCDMA_B_DST_MEM];
    end else begin
      BUS_ADDR = src_addr[chan_reg];
      BUS_MEM  = chan_ctrl_reg[chan_reg][`TCDMA_B_SRC_MEM];
    end
  end

  // pointer steps
  always_comb begin
    step    = chan_ctrl_reg[chan_reg][`TCDMA_B_WORD] ? 20'h00002 : 20'h00001;
    src_adj = src_addr[chan_reg];
    dst_adj = dst_addr[chan_reg];
    if (chan_ctrl_reg[chan_reg][`TCDMA_B_SRC_UP] && !chan_ctrl_reg[chan_reg][`TCDMA_B_SRC_DOWN]) begin
      src_adj = src_addr[chan_reg] + step;
    end else if (!chan_ctrl_reg[chan_reg][`TCDMA_B_SRC_UP]
                 && chan_ctrl_reg[chan_reg][`TCDMA_B_SRC_DOWN]) begin
      src_adj = src_addr[chan_reg] - step;
    end
    if (chan_ctrl_reg[chan_reg][`TCDMA_B_DST_UP] && !chan_ctrl_reg[chan_reg][`TCDMA_B_DST_DOWN]) begin
      dst_adj = dst_addr[chan_reg] + step;
    end else if (!chan_ctrl_reg[chan_reg][`TCDMA_B_DST_UP]
                 && chan_ctrl_reg[chan_reg][`TCDMA_B_DST_DOWN]) begin
      dst_adj = dst_addr[chan_reg] - step;
    end
  end

  // register file: software writes and end-of-transfer updates
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 2; i++) begin
        src_ptr_lo_reg[i] <= 16'h0000;
        src_ptr_hi_reg[i] <= 16'h0000;
        dst_ptr_lo_reg[i] <= 16'h0000;
        dst_ptr_hi_reg[i] <= 16'h0000;
        count_reg[i]      <= 16'h0000;
        chan_ctrl_reg[i]  <= 16'h0000;
      end
    end else begin
      if (xfer_end) begin
        src_ptr_lo_reg[chan_reg] <= src_adj[15:0];
        src_ptr_hi_reg[chan_reg] <= {12'h000, src_adj[19:16]};
        dst_ptr_lo_reg[chan_reg] <= dst_adj[15:0];
        dst_ptr_hi_reg[chan_reg] <= {12'h000, dst_adj[19:16]};
        count_reg[chan_reg]      <= count_reg[chan_reg] - 16'h0001;
        if (count_reg[chan_reg] == 16'h0001 &&
            (chan_ctrl_reg[chan_reg][`TCDMA_B_TC_STOP] ||
             chan_ctrl_reg[chan_reg][`TCDMA_B_SYNC_HI:`TCDMA_B_SYNC_LO] == SYNC_NONE)) begin
          chan_ctrl_reg[chan_reg][`TCDMA_B_ARM] <= 1'b0;
        end
      end
      if (wr_en && PADDR[11:6] == 6'h00) begin
        if (sel_off == `TCDMA_OFF_SRC_LO) begin
          src_ptr_lo_reg[sel_ch] <= PWDATA[15:0];
        end else if (sel_off == `TCDMA_OFF_SRC_HI) begin
          src_ptr_hi_reg[sel_ch] <= {12'h000, PWDATA[3:0]};
        end else if (sel_off == `TCDMA_OFF_DST_LO) begin
          dst_ptr_lo_reg[sel_ch] <= PWDATA[15:0];
        end else if (sel_off == `TCDMA_OFF_DST_HI) begin
          dst_ptr_hi_reg[sel_ch] <= {12'h000, PWDATA[3:0]};
        end else if (sel_off == `TCDMA_OFF_COUNT) begin
          count_reg[sel_ch] <= PWDATA[15:0];
        end else if (sel_off == `TCDMA_OFF_CTRL) begin
          chan_ctrl_reg[sel_ch][15:3] <= PWDATA[15:3] & 13'(`TCDMA_CTRL_WMASK >> 3);
          chan_ctrl_reg[sel_ch][`TCDMA_B_WORD] <= PWDATA[`TCDMA_B_WORD];
          if (PWDATA[`TCDMA_B_ARM_GUARD]) begin
            chan_ctrl_reg[sel_ch][`TCDMA_B_ARM] <= PWDATA[`TCDMA_B_ARM];
          end
        end
      end
    end
  end

  // timer request latch and terminal-count interrupt flags
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      timer_pend_reg <= 2'h0;
      irq_reg        <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (TIMER2_REQ) begin
          timer_pend_reg[i] <= 1'b1;
        end else if (xfer_end && chan_reg == i[0]) begin
          timer_pend_reg[i] <= 1'b0;
        end
        if (xfer_end && chan_reg == i[0] && count_reg[i] == 16'h0001
            && chan_ctrl_reg[i][`TCDMA_B_TC_STOP] && chan_ctrl_reg[i][`TCDMA_B_IRQ_ZERO]) begin
          irq_reg[i] <= 1'b1;
        end else if (wr_en && PADDR[11:0] == `TCDMA_OFF_STATUS && PWDATA[i]) begin
          irq_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign IRQ_REQ = irq_reg;

  // read data
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h00000000;
    end else if (rd_en && !PENABLE) begin
      if (PADDR[11:6] != 6'h00) begin
        PRDATA <= (PADDR[11:0] == `TCDMA_OFF_STATUS) ?
                  {28'h0000000, last_dst_reg, BUS_REQ, irq_reg} : 32'h00000000;
      end else if (sel_off == `TCDMA_OFF_SRC_LO) begin
        PRDATA <= {16'h0000, src_ptr_lo_reg[sel_ch]};
      end else if (sel_off == `TCDMA_OFF_SRC_HI) begin
        PRDATA <= {16'h0000, src_ptr_hi_reg[sel_ch]};
      end else if (sel_off == `TCDMA_OFF_DST_LO) begin
        PRDATA <= {16'h0000, dst_ptr_lo_reg[sel_ch]};
      end else if (sel_off == `TCDMA_OFF_DST_HI) begin
        PRDATA <= {16'h0000, dst_ptr_hi_reg[sel_ch]};
      end else if (sel_off == `TCDMA_OFF_COUNT) begin
        PRDATA <= {16'h0000, count_reg[sel_ch]};
      end else if (sel_off == `TCDMA_OFF_CTRL) begin
        PRDATA <= {16'h0000, chan_ctrl_reg[sel_ch]};
      end else begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  sequence s_deposit_done;
    state_reg == ST_DEPOSIT && BUS_DONE;
  endsequence

  a_fixed_high_first: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_reg == ST_IDLE && req == 2'b11 && high == 2'b10 && !yield_reg
    |=> chan_reg == 1'b1)
    else $error("high priority channel not granted first");
  a_dst_idle_two: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_deposit_done ##0 chan_ctrl_reg[chan_reg][7:6] == 2'b10
    |=> state_reg == ST_RELEASE [*2] ##1 state_reg == ST_IDLE)
    else $error("destination idle release not two cycles");
  a_fetch_src_addr: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_reg == ST_FETCH
    |-> BUS_ADDR == {src_ptr_hi_reg[chan_reg][3:0], src_ptr_lo_reg[chan_reg]}
        && !BUS_WRITE && BUS_REQ)
    else $error("fetch address not source pointer");
  a_rotate_after: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_deposit_done ##0 chan_ctrl_reg[chan_reg][7:6] != 2'b10
    |=> rot_top_reg == ~$past(chan_reg))
    else $error("rotation not updated");
  a_arm_guard: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    wr_en && PADDR[11:0] == `TCDMA_OFF_CTRL && !PWDATA[2] && !xfer_end
    |=> chan_ctrl_reg[0][1] == $past(chan_ctrl_reg[0][1]))
    else $error("arm changed without guard");
  a_step_word: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_deposit_done ##0 chan_ctrl_reg[chan_reg][10] && !chan_ctrl_reg[chan_reg][11]
    ##0 chan_ctrl_reg[chan_reg][0] |-> src_adj == src_addr[chan_reg] + 20'h00002)
    else $error("word step not two");
  a_hold_equal: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    chan_ctrl_reg[chan_reg][13] == chan_ctrl_reg[chan_reg][14]
    |-> dst_adj == dst_addr[chan_reg])
    else $error("pointer moved with equal step bits");
  a_tc_disarm: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_deposit_done ##0 count_reg[chan_reg] == 16'h0001 ##0 chan_ctrl_reg[chan_reg][9]
    ##0 !(wr_en && PADDR[5:0] == 6'h14) |=> !chan_ctrl_reg[$past(chan_reg)][1])
    else $error("channel not disarmed at terminal count");
  a_release_yield: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_reg == ST_IDLE && req == 2'b11 && high == 2'b10 && yield_reg && chan_reg
    |=> chan_reg == 1'b0)
    else $error("released high channel did not yield one transfer");
  a_rot_reset: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_reg == ST_RELEASE |=> rot_top_reg == 1'b1)
    else $error("rotation not back on channel 1 after release");
  a_irq_needs_stop: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !irq_reg[0] ##1 irq_reg[0] |-> $past(chan_ctrl_reg[0][9]) && $past(chan_ctrl_reg[0][8]))
    else $error("interrupt raised without terminal stop");
  a_suspend_blocks: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_reg == ST_IDLE && SUSPEND |=> state_reg == ST_IDLE)
    else $error("transfer started while suspended");
  a_pin_ignored: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_reg == ST_IDLE && chan_ctrl_reg[0][4] && chan_ctrl_reg[0][7:6] != 2'b00
    && !timer_pend_reg[0] && !chan_ctrl_reg[1][1] |=> state_reg == ST_IDLE)
    else $error("timer-fed channel started without timer request");

endmodule

// >>> hdl/tcdma_map.svh
`ifndef TCDMA_MAP_SVH
`define TCDMA_MAP_SVH
// per-channel window of 8 words, channel n at n*0x20
`define TCDMA_CH_STRIDE      12'h020
`define TCDMA_OFF_SRC_LO     12'h000
`define TCDMA_OFF_SRC_HI     12'h004
`define TCDMA_OFF_DST_LO     12'h008
`define TCDMA_OFF_DST_HI     12'h00c
`define TCDMA_OFF_COUNT      12'h010
`define TCDMA_OFF_CTRL       12'h014
`define TCDMA_OFF_STATUS     12'h040
// control field positions
`define TCDMA_B_DST_MEM      15
`define TCDMA_B_DST_DOWN     14
`define TCDMA_B_DST_UP       13
`define TCDMA_B_SRC_MEM      12
`define TCDMA_B_SRC_DOWN     11
`define TCDMA_B_SRC_UP       10
`define TCDMA_B_TC_STOP      9
`define TCDMA_B_IRQ_ZERO     8
`define TCDMA_B_SYNC_HI      7
`define TCDMA_B_SYNC_LO      6
`define TCDMA_B_RANK_HIGH    5
`define TCDMA_B_TIMER_SEL    4
`define TCDMA_B_ARM_GUARD    2
`define TCDMA_B_ARM          1
`define TCDMA_B_WORD         0
// writable control bits (guard and reserved read zero)
`define TCDMA_CTRL_WMASK     16'hfff1
`define TCDMA_IDLE_CYCLES    2'h2
`endif

// >>> hdl/tcdma_pkg.sv
package tcdma_pkg;
  typedef enum logic [1:0] {
    SYNC_NONE,
    SYNC_SRC,
    SYNC_DST,
    SYNC_RSVD
  } tcdma_sync_t;
  typedef enum {
    ST_IDLE,
    ST_FETCH,
    ST_DEPOSIT,
    ST_RELEASE
  } tcdma_state_t;
endpackage

// >>> verification/tcdma_biu_model.sv
`timescale 1ns/1ps
// bus unit stand-in: ends each pending phase after a short or a long wait
module tcdma_biu_model (
  input  wire logic sys_clk,   // system clock
  input  wire logic rstn,      // async reset, active low
  input  wire logic slow,      // 1 stretches every phase
  input  wire logic bus_req,   // phase pending from the dma
  output logic      bus_done   // one-cycle end of phase
);
  logic [2:0] wait_reg;

  // a cycle of rest after each done keeps phases from merging
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 3'h0;
      bus_done <= 1'b0;
    end else if (bus_done || !bus_req) begin
      wait_reg <= 3'h0;
      bus_done <= 1'b0;
    end else if (wait_reg >= (slow ? 3'h4 : 3'h1)) begin
      wait_reg <= 3'h0;
      bus_done <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 3'h1;
    end
  end
endmodule

// >>> verification/tcdma_top_tb.sv
`timescale 1ns/1ps
`include "tcdma_map.svh"
module tcdma_top_tb;
  localparam logic [11:0] CT0 = `TCDMA_OFF_CTRL;
  localparam logic [11:0] CT1 = `TCDMA_OFF_CTRL + `TCDMA_CH_STRIDE;
  localparam logic [31:0] ARM = 32'h0000_0006;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        t2 = 1'b0;
  logic        sus = 1'b0;
  logic        slow = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [1:0]  req = 2'h0;
  logic [31:0] prd;
  logic        pready;
  logic        slverr;
  logic        done;
  logic        breq;
  logic        bwr;
  logic        bmem;
  logic        bword;
  logic        bch;
  logic [19:0] badr;
  logic [1:0]  irq;
  logic [23:0] q[$];
  int          mismatches = 0;
  int          cmp_count = 0;
  int          ndep = 0;
  int          cyc = 0;

  tcdma_top i_dut (.SYS_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(slverr),
    .EXT_REQ_PIN(req),
    .TIMER2_REQ(t2), .SUSPEND(sus), .BUS_REQ(breq), .BUS_DONE(done), .BUS_ADDR(badr),
    .BUS_MEM(bmem), .BUS_WRITE(bwr), .BUS_WORD(bword), .BUS_CHAN(bch), .IRQ_REQ(irq));
  tcdma_biu_model i_biu (.sys_clk(clk), .rstn(rstn), .slow(slow), .bus_req(breq),
    .bus_done(done));

  always #50 clk = ~clk;

  // log every finished phase: {write, mem, word, chan, addr}
  always @(posedge clk) begin
    if (rstn && breq && done) begin
      q.push_back({bwr, bmem, bword, bch, badr});
      if (bwr) ndep++;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task test_done();
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask

  // upper nibble and reserved bits are written as zero where unused
  task setp(input logic [11:0] b, input logic [19:0] s, input logic [19:0] d,
            input logic [15:0] n);
    wr(b, {16'h0, s[15:0]});
    wr(b + 12'h004, {28'h0, s[19:16]});
    wr(b + 12'h008, {16'h0, d[15:0]});
    wr(b + 12'h00c, {28'h0, d[19:16]});
    wr(b + 12'h010, {16'h0, n});
  endtask

  task pop(input logic [23:0] e);
    int n;
    n = 0;
    while (q.size() == 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk((q.size() > 0) ? {8'h0, q.pop_front()} : 32'hffff_ffff, {8'h0, e});
  endtask

  // one byte i/o transfer with held pointers of the arbitration setup
  task xf(input logic c);
    pop({3'b000, c, c ? 20'h00300 : 20'h00100});
    pop({3'b100, c, c ? 20'h00400 : 20'h00200});
  endtask

  task skip(input int k);
    int t;
    int n;
    t = ndep + k;
    n = 0;
    while (ndep < t && n < 400) begin
      @(posedge clk);
      n++;
    end
    q.delete();
  endtask

  task stop();
    int n;
    int c;
    req <= 2'b00;
    wr(CT0, 32'h4);
    wr(CT1, 32'h4);
    n = 0;
    c = 0;
    while (c < 6 && n < 400) begin
      @(posedge clk);
      c = breq ? 0 : c + 1;
      n++;
    end
    q.delete();
  endtask

  task arb(input logic [31:0] c1, input logic [31:0] c0, input logic [7:0] seq, input int n);
    wr(CT1, c1 | ARM);
    wr(CT0, c0 | ARM);
    req <= 2'b11;
    for (int i = 0; i < n; i++) xf(seq[i]);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(12'h00c, 32'h0);
    rd(CT1, 32'h0);
    setp(12'h000, 20'h12345, 20'h6789a, 16'h0002);
    rd(12'h000, 32'h2345);
    rd(12'h004, 32'h1);
    wr(CT0, 32'hff73);
    rd(CT0, 32'hff71);
    wr(CT0, 32'hff77);
    rd(CT0, 32'hff73);
    wr(12'h7fc, 32'h1234);
    rd(12'h7fc, 32'h0);
    chk({31'h0, slverr}, 32'h0);
    // unsynchronised word run: source memory up, destination i/o down
    wr(CT0, 32'h5701 | ARM);
    pop({3'b011, 1'b0, 20'h12345});
    pop({3'b101, 1'b0, 20'h6789a});
    pop({3'b011, 1'b0, 20'h12347});
    pop({3'b101, 1'b0, 20'h67898});
    rd(12'h000, 32'h2349);
    rd(12'h008, 32'h7896);
    rd(CT0, 32'h5701);
    chk({30'h0, irq}, 32'h1);
    rd(12'h040, 32'h1, 32'h3);
    wr(12'h040, 32'h1);
    rd(12'h040, 32'h0, 32'h3);
    chk(32'(q.size()), 32'h0);
    // byte run on channel 1: source i/o held, destination memory up
    setp(12'h020, 20'h30050, 20'h000ff, 16'h0001);
    wr(CT1, 32'had00 | ARM);
    pop({3'b000, 1'b1, 20'h30050});
    pop({3'b110, 1'b1, 20'h000ff});
    rd(12'h020, 32'h0050);
    rd(12'h028, 32'h0100);
    rd(CT1, 32'had00);
    chk({30'h0, irq}, 32'h0);
    // arbitration with held byte i/o pointers
    setp(12'h000, 20'h00100, 20'h00200, 16'hffff);
    setp(12'h020, 20'h00300, 20'h00400, 16'hffff);
    arb(32'h60, 32'h40, 8'h07, 3);
    req <= 2'b01;
    skip(2);
    xf(1'b0);
    xf(1'b0);
    req <= 2'b11;
    skip(2);
    xf(1'b1);
    xf(1'b1);
    stop();
    arb(32'ha0, 32'h40, 8'h05, 4);
    stop();
    for (int p = 0; p < 2; p++) begin
      slow <= p[0];
      arb(p[0] ? 32'h60 : 32'h40, p[0] ? 32'h60 : 32'h40, 8'h05, 4);
      stop();
    end
    slow <= 1'b0;
    arb(32'h80, 32'h80, 8'h07, 3);
    stop();
    // timer-fed channel ignores its pin
    wr(CT0, 32'h50 | ARM);
    req <= 2'b01;
    repeat (20) @(posedge clk);
    chk(32'(q.size()), 32'h0);
    t2 <= 1'b1;
    @(posedge clk);
    t2 <= 1'b0;
    xf(1'b0);
    repeat (20) @(posedge clk);
    chk(32'(q.size()), 32'h0);
    // suspension holds a latched timer request until it is lifted
    sus <= 1'b1;
    t2 <= 1'b1;
    @(posedge clk);
    t2 <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'(q.size()), 32'h0);
    sus <= 1'b0;
    xf(1'b0);
    stop();
    test_done();
  end
endmodule
